// ==== design/srtc_pkg.sv ====
package srtc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_RAM_LAST = 8'h1f;
    localparam logic [7:0] IDX_SEC = 8'h20;
    localparam logic [7:0] IDX_YEAR = 8'h26;
    localparam logic [7:0] IDX_ASEC = 8'h28;
    localparam logic [7:0] IDX_AHR = 8'h2a;
    localparam logic [7:0] IDX_STAT = 8'h30;
    localparam logic [7:0] IDX_CCR = 8'h31;
    localparam logic [7:0] IDX_ICR = 8'h32;
    localparam logic [1:0] IDX_LSB = 2'h2;
    // Hours field layout.
    localparam int HR_12H_BIT = 7;
    localparam int HR_PM_BIT = 5;
    localparam logic [4:0] HR_11 = 5'h11;
    localparam logic [4:0] HR_12 = 5'h12;
    localparam logic [4:0] HR_01 = 5'h01;
    // BCD limits of the calendar chain.
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    // Reset value of the seven time counters, seconds in the low byte.
    localparam logic [55:0] TM_RST = 56'h00_01_01_01_00_00_00;
    // Status register bits.
    localparam int ST_AL_BIT = 0;
    localparam int ST_FTU_BIT = 4;
    localparam int ST_WD_BIT = 6;
    localparam logic [7:0] ST_RST = 8'h10;
    // Timebase: line divides, divider width and the watchdog tap below the top.
    localparam logic [5:0] LINE_DIV50 = 6'h31;
    localparam logic [5:0] LINE_DIV60 = 6'h3b;
    localparam int DIV_W = 22;
    localparam int WD_TAP_DOWN = 6;
    // Watchdog: trips on the second 64 Hz tick, 15.6 to 31.3 ms.
    localparam int WD_RESET_MIN_US = 15600;
    localparam logic [1:0] WD_TRIP = 2'h2;
    localparam logic [1:0] POR_SETTLE = 2'h3;

    typedef struct packed {
        logic start;
        logic line_sel;
        logic [1:0] xsel;
        logic line60;
        logic [2:0] freq;
    } srtc_ccr_t;

    typedef struct packed {
        logic wd_en;
        logic pd;
        logic psense;
        logic al_en;
        logic [3:0] per;
    } srtc_icr_t;

    typedef enum logic [1:0] {
        PW_POR = 2'b00,
        PW_OFF = 2'b01,
        PW_ON = 2'b10
    } srtc_pw_t;
endpackage : srtc_pkg

// ==== design/srtc_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Latch supply mode from voltage sense at reset.
// - Single supply enables all outputs after reset.
// - Single supply: sense low pulls processor reset.
// - Single supply: sense low-high ends power-down.
// - Battery mode: outputs low until supply above battery.
// - Battery mode: supply drop disables outputs again.
// - Calendar advances on prescaled oscillator one-second tick.
// - Mains input divided by 50 or 60 instead.
// - Twelve/24 hour format, AM/PM toggles each 12 hours.
// - All counters hold BCD, hours carry format bits.
// - Hours bit 7 selects 12h, bit 5 means PM.
// - Time counters sit at indices 20h to 26h.
// - Indices 00h to 1Fh reach the 32-byte RAM.
// - Low five index bits pick the RAM byte.
// - Alarm fires when seconds, minutes, hours all match.
// - Interrupt pulls low only with alarm enable set.
// - Alarm sets the status alarm flag.
// - Missed watchdog gives reset pulse, status bit 6.
// - Clock control low bits pick square-wave rate.
// - Power-down forces the square-wave output low.
// - Control registers read-write, status register read-only.
// - Interrupt control bit 6 starts power-down.
// - Interrupt stays low until status register is read.
// - Any interrupt ends power-down and restores outputs.
module srtc_top
    import srtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_tick,
    input wire logic line_in,
    input wire logic ce,
    input wire logic system_voltage_sense,
    input wire logic system_voltage_sense_above_batt,
    output logic supply_enable_output,
    output logic square_wave_output,
    output logic processor_reset_output_o,
    output logic processor_reset_output_oe,
    output logic irq_o,
    output logic irq_oe
);
    // One BCD step with wrap from max to lo; bit 8 is the carry.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] max,
                                           input logic [7:0] lo);
        logic [7:0] n;
        n = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return (v == max) ? {1'b1, lo} : {1'b0, n};
    endfunction : bcd_inc

    // Last day of the month; BCD years divisible by four are leap.
    function automatic logic [7:0] month_end(input logic [7:0] mon,
                                             input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[1:0] == 2'h0 && !yr[3]) || yr[3:0] == 4'h8;
        case (mon)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : month_end

    // Divider tap giving a 1 Hz square wave for each crystal choice.
    function automatic logic [4:0] xtal_top(input logic [1:0] xsel);
        case (xsel)
            2'h0: return 5'h0e;
            2'h1: return 5'h13;
            2'h2: return 5'h14;
            default: return 5'h15;
        endcase
    endfunction : xtal_top

    logic [7:0] ram_q [32];
    logic [7:0] tm_q [7];
    logic [7:0] tm_d [7];
    logic [7:0] al_q [3];
    logic [7:0] stat_q;
    srtc_ccr_t ccr_q;
    srtc_icr_t icr_q;
    srtc_pw_t pw_q;
    logic mode_single_q;
    logic [1:0] por_cnt_q;
    logic [1:0] vs_sync_q;
    logic [1:0] ab_sync_q;
    logic vs_s;
    logic ab_s;
    logic vs_low_seen_q;
    logic [DIV_W-1:0] div_q;
    logic [5:0] line_cnt_q;
    logic line_q;
    logic sec_tick;
    logic tick_q;
    logic alarm_hit;
    logic int_pend_q;
    logic ce_q;
    logic wd_tap_q;
    logic [1:0] wd_cnt_q;
    logic wd_fire;
    logic wd_pulse_q;
    logic [7:0] idx;
    logic acc;
    logic wr;
    logic rd_stat;
    logic mapped;
    logic [7:0] rdata;
    logic [4:0] top;
    logic [8:0] c [7];
    logic [4:0] hr12;
    logic [8:0] hc;

    assign idx = paddr[9:2];
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && !pslverr;
    assign rd_stat = acc && !pwrite && idx == IDX_STAT;
    assign top = xtal_top(ccr_q.xsel);

    // Unmapped indices answer with an error and read as zero.
    always_comb begin
        mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
        rdata = 8'h00;
        if (idx <= IDX_RAM_LAST) begin
            rdata = ram_q[idx[4:0]];
        end else if (idx >= IDX_SEC && idx <= IDX_YEAR) begin
            rdata = tm_q[3'(idx - IDX_SEC)];
        end else if (idx >= IDX_ASEC && idx <= IDX_AHR) begin
            rdata = al_q[2'(idx - IDX_ASEC)];
        end else if (idx == IDX_STAT) begin
            rdata = stat_q;
        end else if (idx == IDX_CCR) begin
            rdata = ccr_q;
        end else if (idx == IDX_ICR) begin
            rdata = icr_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave: read data is registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable) begin
                // Unmapped or misaligned requests read as zero.
                prdata <= {24'h00_0000, mapped ? rdata : 8'h00};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_sync_q <= 2'h0;
            ab_sync_q <= 2'h0;
        end else begin
            vs_sync_q <= {vs_sync_q[0], system_voltage_sense};
            ab_sync_q <= {ab_sync_q[0], system_voltage_sense_above_batt};
        end
    end
    assign vs_s = vs_sync_q[1];
    assign ab_s = ab_sync_q[1];

    always_ff @(posedge pclk) begin
        if (wr && idx <= IDX_RAM_LAST) begin
            ram_q[idx[4:0]] <= pwdata[7:0];
        end
    end

    // Control registers; power-down lives in the interrupt control.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccr_q <= '0;
            icr_q <= '0;
        end else begin
            if (wr && idx == IDX_CCR) begin
                ccr_q <= pwdata[7:0];
            end
            if (wr && idx == IDX_ICR) begin
                icr_q <= pwdata[7:0];
            end else if (icr_q.pd) begin
                if (alarm_hit && icr_q.al_en) begin
                    icr_q.pd <= 1'b0;
                end else if (mode_single_q && vs_low_seen_q && vs_s) begin
                    icr_q.pd <= 1'b0;
                end else if (!mode_single_q && pw_q == PW_OFF && ab_s) begin
                    icr_q.pd <= 1'b0;
                end
            end
        end
    end

    // Remembers a low sense level seen during power-down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_low_seen_q <= 1'b0;
        end else begin
            vs_low_seen_q <= icr_q.pd && (vs_low_seen_q || !vs_s);
        end
    end

    // mode latch
    // Waits for the synchroniser to fill before trusting the level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt_q <= 2'h0;
            mode_single_q <= 1'b0;
            pw_q <= PW_POR;
        end else begin
            case (pw_q)
                PW_POR: begin
                    por_cnt_q <= por_cnt_q + 2'h1;
                    if (por_cnt_q == POR_SETTLE) begin
                        mode_single_q <= vs_s;
                        pw_q <= vs_s ? PW_ON : PW_OFF;
                    end
                end
                PW_OFF: begin
                    if (mode_single_q || ab_s) begin
                        pw_q <= PW_ON;
                    end
                end
                PW_ON: begin
                    if (!mode_single_q && !ab_s) begin
                        pw_q <= PW_OFF;
                    end
                end
                default: pw_q <= PW_POR;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            line_cnt_q <= 6'h00;
            line_q <= 1'b0;
        end else begin
            line_q <= line_in;
            if (osc_tick) begin
                div_q <= (div_q[top] && &(div_q | ~((DIV_W'(1) << top)
                         - DIV_W'(1)))) ? '0 : div_q + DIV_W'(1);
            end
            if (line_in && !line_q) begin
                if (line_cnt_q == (ccr_q.line60 ? LINE_DIV60
                                                : LINE_DIV50)) begin
                    line_cnt_q <= 6'h00;
                end else begin
                    line_cnt_q <= line_cnt_q + 6'h01;
                end
            end
        end
    end

    // The second ends when the chosen divider wraps, stop gates it.
    assign sec_tick = ccr_q.start && (ccr_q.line_sel
        ? (line_in && !line_q && line_cnt_q == (ccr_q.line60
           ? LINE_DIV60 : LINE_DIV50))
        : (osc_tick && div_q[top] && &(div_q | ~((DIV_W'(1) << top)
           - DIV_W'(1)))));

    always_comb begin
        hr12 = tm_q[2][4:0];
        if (hr12 == HR_12) begin
            hc = {1'b0, tm_q[2][7:5], HR_01};
        end else if (hr12 == HR_11) begin
            hc = {tm_q[2][HR_PM_BIT], tm_q[2][7:6],
                  ~tm_q[2][HR_PM_BIT], HR_12};
        end else begin
            hc = {1'b0, tm_q[2][7:5], 5'(bcd_inc({3'h0, hr12},
                  BCD_59, BCD_00))};
        end
        c[0] = bcd_inc(tm_q[0], BCD_59, BCD_00);
        c[1] = bcd_inc(tm_q[1], BCD_59, BCD_00);
        c[2] = tm_q[2][HR_12H_BIT] ? hc : bcd_inc(tm_q[2], BCD_23, BCD_00);
        c[3] = bcd_inc(tm_q[3], BCD_07, BCD_01);
        c[4] = bcd_inc(tm_q[4], month_end(tm_q[5], tm_q[6]), BCD_01);
        c[5] = bcd_inc(tm_q[5], BCD_12, BCD_01);
        c[6] = bcd_inc(tm_q[6], BCD_99, BCD_00);
        tm_d[0] = c[0][7:0];
        tm_d[1] = c[0][8] ? c[1][7:0] : tm_q[1];
        tm_d[2] = (c[0][8] && c[1][8]) ? c[2][7:0] : tm_q[2];
        tm_d[3] = (c[0][8] && c[1][8] && c[2][8]) ? c[3][7:0] : tm_q[3];
        tm_d[4] = (c[0][8] && c[1][8] && c[2][8]) ? c[4][7:0] : tm_q[4];
        tm_d[5] = (c[0][8] && c[1][8] && c[2][8] && c[4][8])
                  ? c[5][7:0] : tm_q[5];
        tm_d[6] = (c[0][8] && c[1][8] && c[2][8] && c[4][8] && c[5][8])
                  ? c[6][7:0] : tm_q[6];
    end

    // BCD time counters
    // A software write wins over the tick in the same cycle.
    for (genvar i = 0; i < 7; i++) begin : g_tm
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tm_q[i] <= TM_RST[8*i +: 8];
            end else if (wr && idx == IDX_SEC + 8'(i)) begin
                tm_q[i] <= pwdata[7:0];
            end else if (sec_tick) begin
                tm_q[i] <= tm_d[i];
            end
        end
    end

    // Alarm latches, written only by software.
    for (genvar i = 0; i < 3; i++) begin : g_al
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                al_q[i] <= 8'h00;
            end else if (wr && idx == IDX_ASEC + 8'(i)) begin
                al_q[i] <= pwdata[7:0];
            end
        end
    end

    // alarm compare
    // Checked once per second, after the counters have moved.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= sec_tick;
        end
    end
    assign alarm_hit = tick_q && tm_q[0] == al_q[0] && tm_q[1] == al_q[1]
                       && tm_q[2][5:0] == al_q[2][5:0];

    // watchdog
    // Counts 64 Hz ticks since the last chip-enable edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_q <= 1'b0;
            wd_tap_q <= 1'b0;
            wd_cnt_q <= 2'h0;
            wd_pulse_q <= 1'b0;
        end else begin
            ce_q <= ce;
            wd_tap_q <= div_q[5'(top - 5'(WD_TAP_DOWN))];
            if (!icr_q.wd_en || ce != ce_q || wd_fire) begin
                wd_cnt_q <= 2'h0;
            end else if (div_q[5'(top - 5'(WD_TAP_DOWN))] && !wd_tap_q) begin
                wd_cnt_q <= wd_cnt_q + 2'h1;
            end
            if (wd_fire) begin
                wd_pulse_q <= 1'b1;
            end else if (div_q[5'(top - 5'(WD_TAP_DOWN))] && !wd_tap_q) begin
                wd_pulse_q <= 1'b0;
            end
        end
    end
    assign wd_fire = icr_q.wd_en && wd_cnt_q == WD_TRIP;

    // status flags
    // A new event in the reading cycle survives the clearing read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= ST_RST;
            int_pend_q <= 1'b0;
        end else begin
            if (rd_stat) begin
                stat_q <= 8'h00;
            end
            if (alarm_hit) begin
                stat_q[ST_AL_BIT] <= 1'b1;
            end
            if (wd_fire) begin
                stat_q[ST_WD_BIT] <= 1'b1;
            end
            int_pend_q <= (alarm_hit && icr_q.al_en)
                          || (int_pend_q && !rd_stat);
        end
    end

    // Output pins; the open-drain pins pull low when enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_enable_output <= 1'b0;
            square_wave_output <= 1'b0;
            processor_reset_output_oe <= 1'b1;
            irq_oe <= 1'b0;
        end else begin
            supply_enable_output <= pw_q == PW_ON && !icr_q.pd;
            square_wave_output <= pw_q == PW_ON && !icr_q.pd
                && ccr_q.freq != 3'h0
                && div_q[5'(top - 5'(3'h7 - ccr_q.freq))];
            processor_reset_output_oe <= pw_q != PW_ON || icr_q.pd
                || (mode_single_q && !vs_s) || wd_pulse_q;
            irq_oe <= int_pend_q;
        end
    end
    assign processor_reset_output_o = 1'b0;
    assign irq_o = 1'b0;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pd_write;
        wr && idx == IDX_ICR && pwdata[HR_PM_BIT + 1];
    endsequence
    sequence s_stat_read;
        rd_stat && !(alarm_hit && icr_q.al_en);
    endsequence

    property p_mode_latch;
        pw_q == PW_POR && por_cnt_q == POR_SETTLE |=> mode_single_q == $past(vs_s);
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode latch");
    property p_single_on;
        pw_q == PW_POR && por_cnt_q == POR_SETTLE && vs_s |=> pw_q == PW_ON;
    endproperty
    a_single_on: assert property (p_single_on) else $error("single on");
    property p_processor_reset_output_low;
        mode_single_q && !vs_s |=> processor_reset_output_oe;
    endproperty
    a_processor_reset_output_low: assert property (p_processor_reset_output_low) else $error("processor_reset_output low");
    property p_batt_off;
        !mode_single_q && pw_q == PW_ON && !ab_s |=> ##1 !supply_enable_output;
    endproperty
    a_batt_off: assert property (p_batt_off) else $error("batt off");
    property p_alarm_flag;
        alarm_hit |=> stat_q[ST_AL_BIT];
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm");
    property p_int_low;
        alarm_hit && icr_q.al_en |=> ##1 irq_oe;
    endproperty
    a_int_low: assert property (p_int_low) else $error("int low");
    property p_pd_off;
        s_pd_write |=> ##1 !supply_enable_output && !square_wave_output;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("power-down");
    property p_wd;
        wd_fire |=> stat_q[ST_WD_BIT] ##1 processor_reset_output_oe;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog");
    property p_int_release;
        s_stat_read |=> ##1 !irq_oe;
    endproperty
    a_int_release: assert property (p_int_release) else $error("release");
endmodule : srtc_top

// ==== verification/srtc_far_end.sv ====
`timescale 1ns/100ps
// Host side: pulled-up reset and interrupt lines, plus timebase sources.
module srtc_far_end (
    input wire logic pclk,
    input wire logic rst_o,
    input wire logic rst_oe,
    input wire logic irq_o,
    input wire logic irq_oe,
    output logic cpu_reset_n,
    output logic int_n,
    output logic line_in,
    output logic osc_tick
);
    logic [1:0] ph_q;
    // Open-drain lines rise to the pull-up level when nobody pulls.
    assign cpu_reset_n = rst_oe ? rst_o : 1'b1;
    assign int_n = irq_oe ? irq_o : 1'b1;
    // A tick each cycle gives 32768 cycles per second at the slow crystal.
    assign osc_tick = 1'b1;
    // A four-cycle mains wave keeps a 50 Hz line-driven second at 200 cycles.
    initial ph_q = 2'h0;
    // Plain always, since the phase also takes its start value above.
    always @(posedge pclk) begin
        ph_q <= ph_q + 2'h1;
    end
    assign line_in = ph_q[1];
endmodule : srtc_far_end

// ==== verification/tb.sv ====
`timescale 1ns/100ps
// Drives the clock block over its register bus and checks its pins.
module tb;
    import srtc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, ce, sense, above, err, p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, osc_tick, line_in, se, sq;
    logic rst_o, rst_oe, irq_o, irq_oe, cpu_reset_n, int_n;
    logic [3:0] obs;
    logic [7:0] rd;
    logic [7:0] tv [7];
    logic [7:0] ev [7];
    int n_fail, n_tests, k, m, f;
    assign obs = {se, sq, cpu_reset_n, int_n};
    srtc_top srtc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_tick(osc_tick), .line_in(line_in),
        .ce(ce), .system_voltage_sense(sense), .system_voltage_sense_above_batt(above),
        .supply_enable_output(se), .square_wave_output(sq),
        .processor_reset_output_o(rst_o),
        .processor_reset_output_oe(rst_oe), .irq_o(irq_o),
        .irq_oe(irq_oe));
    srtc_far_end srtc_far_end_i (.pclk(pclk), .rst_o(rst_o),
        .rst_oe(rst_oe), .irq_o(irq_o), .irq_oe(irq_oe),
        .cpu_reset_n(cpu_reset_n), .int_n(int_n), .line_in(line_in),
        .osc_tick(osc_tick));
    // Free-running 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task stop_test;
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Case equality, so an unknown never passes.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // A wait that ran out of its bound ends the run as a failure.
    task limit(input logic ok);
        chk({7'h0, ok}, 8'h01);
        if (ok !== 1'b1)
            stop_test();
    endtask : limit
    // One transfer, held until pready is sampled high.
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        limit(pready === 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits at most n cycles for pin b to reach v.
    task wait_for(input int b, input logic v, input int n);
        int i;
        for (i = 0; i < n && obs[b] !== v; i++)
            @(posedge pclk);
        chk({7'h0, obs[b]}, {7'h0, v});
        if (obs[b] !== v)
            stop_test();
    endtask : wait_for
    task do_reset(input logic lvl);
        presetn <= 1'b0;
        sense <= lvl;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : do_reset
    // Main sequence; pins are 3 supply, 2 square, 1 reset, 0 interrupt.
    initial begin
        n_fail = 0;
        n_tests = 0;
        {psel, penable, pwrite, ce, above, presetn, sense} = 7'h01;
        paddr = 12'h000;
        pwdata = 32'h0;
        tv = '{8'h59, 8'h59, 8'hb1, 8'h07, 8'h28, 8'h02, 8'h04};
        ev = '{8'h00, 8'h00, 8'h92, 8'h01, 8'h29, 8'h02, 8'h04};
        do_reset(1'b1);
        wait_for(3, 1'b1, 0);
        wait_for(1, 1'b1, 0);
        apb(1'b1, IDX_STAT, 8'hff);
        apb(1'b0, IDX_STAT, 8'h00);
        chk(rd, ST_RST);
        apb(1'b1, IDX_CCR, 8'h5a);
        apb(1'b0, IDX_CCR, 8'h00);
        chk(rd, 8'h5a);
        apb(1'b1, 8'h00, 8'ha5);
        apb(1'b1, IDX_RAM_LAST, 8'h3c);
        apb(1'b0, 8'h00, 8'h00);
        chk(rd, 8'ha5);
        apb(1'b0, IDX_RAM_LAST, 8'h00);
        chk(rd, 8'h3c);
        apb(1'b0, 8'h27, 8'h00);
        chk({7'h0, err}, 8'h01);
        // Square rate n gives 8 >> n edges in 1024 cycles, give or take one.
        for (f = 1; f < 3; f++) begin
            apb(1'b1, IDX_CCR, 8'(f));
            m = 0;
            p = sq;
            for (k = 0; k < 1024; k++) begin
                @(posedge pclk);
                m += (sq !== p) ? 1 : 0;
                p = sq;
            end
            chk(8'(m >= (8 >> f) - 1 && m <= (8 >> f) + 1), 8'h01);
        end
        // Time is loaded with the alarm disabled and the counters stopped.
        for (k = 0; k < 7; k++)
            apb(1'b1, 8'(IDX_SEC + k), tv[k]);
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 8'(IDX_SEC + k), 8'h00);
            chk(rd, tv[k]);
        end
        apb(1'b1, IDX_CCR, 8'hc1);
        m = 0;
        do begin
            apb(1'b0, IDX_SEC, 8'h00);
            m++;
        end while (rd === 8'h59 && m < 200);
        limit(rd !== 8'h59);
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 8'(IDX_SEC + k), 8'h00);
            chk(rd, ev[k]);
        end
        apb(1'b1, IDX_ASEC, 8'h02);
        apb(1'b1, 8'(IDX_ASEC + 1), 8'h00);
        apb(1'b1, IDX_AHR, 8'h12);
        apb(1'b1, IDX_ICR, 8'h50);
        wait_for(3, 1'b0, 8);
        m = 0;
        for (k = 0; k < 1000 && int_n !== 1'b0; k++) begin
            @(posedge pclk);
            m += (sq !== 1'b0) ? 1 : 0;
        end
        chk(8'(m != 0), 8'h00);
        wait_for(0, 1'b0, 0);
        wait_for(3, 1'b1, 8);
        m = 0;
        do begin
            apb(1'b0, IDX_SEC, 8'h00);
            m++;
        end while (rd !== 8'h03 && m < 100);
        limit(rd === 8'h03);
        apb(1'b0, IDX_STAT, 8'h00);
        chk(rd, 8'h01);
        repeat (3) @(posedge pclk);
        wait_for(0, 1'b1, 0);
        apb(1'b1, IDX_ICR, 8'h40);
        wait_for(3, 1'b0, 8);
        // The low sense level must stand long enough to pass the sync.
        sense <= 1'b0;
        repeat (4) @(posedge pclk);
        sense <= 1'b1;
        wait_for(3, 1'b1, 8);
        wait_for(1, 1'b1, 8);
        // Outside power-down the reset pin must follow the sense alone.
        sense <= 1'b0;
        wait_for(1, 1'b0, 8);
        sense <= 1'b1;
        wait_for(1, 1'b1, 8);
        // Chip enable toggled every 50 cycles keeps the watchdog quiet.
        apb(1'b1, IDX_ICR, 8'h80);
        m = 0;
        for (k = 0; k < 1500; k++) begin
            @(posedge pclk);
            if (k % 50 == 0)
                ce <= ~ce;
            m += (cpu_reset_n !== 1'b1) ? 1 : 0;
        end
        chk(8'(m != 0), 8'h00);
        wait_for(1, 1'b0, 2000);
        wait_for(1, 1'b1, 1100);
        apb(1'b0, IDX_STAT, 8'h00);
        chk(rd, 8'h40);
        apb(1'b1, IDX_ICR, 8'h00);
        do_reset(1'b0);
        wait_for(3, 1'b0, 0);
        wait_for(1, 1'b0, 0);
        above <= 1'b1;
        wait_for(3, 1'b1, 16);
        wait_for(1, 1'b1, 16);
        above <= 1'b0;
        wait_for(3, 1'b0, 16);
        wait_for(1, 1'b0, 16);
        stop_test();
    end
endmodule : tb
